/* File: testbench.sv */
// Purpose: Command-level tests of the alarm core
// Assumes: Converter model answers starts; inputs change at falling edges
// Notes: FP shortens the rate period; slowest code is 128 times FP
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tmal_pkg::*;
	localparam int FP = 20;
	localparam int LAT = 40;
	logic clock_in, rst_in, ara_rd_in, rd_valid_out, ara_ack_out, adc_start_out, adc_done_in;
	logic diode_open_in, diode_short_in, hw_standby_pin_n_in, alert_n_out, alert_oe_out, busy_out;
	logic [7:0] rd_data_out, ara_data_out, adc_local_in, adc_remote_in, lt, rt;
	logic [6:0] own_addr_in;
	tmal_cmd_t cmd_in;
	int compares = 0;
	int miscompares = 0;
	int cycles = 0;
	int starts = 0;
	int g, k, p;
	logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
	logic [7:0] rc [3] = '{8'h05, 8'h07, 8'h0E};
	tmal_core #(.FAST_PERIOD(FP)) tmal_core_i (.clock_in, .rst_in, .cmd_in, .rd_data_out,
		.rd_valid_out, .ara_rd_in, .ara_ack_out, .ara_data_out, .own_addr_in, .adc_start_out,
		.adc_done_in, .adc_local_in, .adc_remote_in, .diode_open_in, .diode_short_in,
		.hw_standby_pin_n_in, .alert_n_out, .alert_oe_out, .busy_out);
	tmal_adc_model #(.LAT(LAT)) tmal_adc_model_i (.clock_in, .start_in(adc_start_out),
		.done_out(adc_done_in), .lt_in(lt), .rt_in(rt), .lt_out(adc_local_in),
		.rt_out(adc_remote_in));
	// =====
	// Clock, 4 ns period
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	// Hang guard well above the planned run
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			summarize();
		end
	end
	// Start pulses counted at the next edge, so a pulse inside a command task is never lost
	always @(posedge clock_in) begin
		if (adc_start_out === 1'b1) begin
			starts <= starts + 1;
		end
	end
	task automatic summarize;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// =====
	// Command tasks; a write lets one extra cycle pass so its effect is visible
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(negedge clock_in);
		cmd_in = '{1'b1, 1'b1, c, d};
		@(negedge clock_in);
		cmd_in.valid = 1'b0;
		@(negedge clock_in);
	endtask
	task automatic rdc(input logic [7:0] c, input logic [7:0] e);
		@(negedge clock_in);
		cmd_in = '{1'b1, 1'b0, c, 8'h00};
		@(negedge clock_in);
		cmd_in.valid = 1'b0;
		chk(rd_valid_out ? rd_data_out : 8'hEE, e);
	endtask
	task automatic ara;
		@(negedge clock_in);
		ara_rd_in = 1'b1;
		@(negedge clock_in);
		ara_rd_in = 1'b0;
		@(negedge clock_in);
	endtask
	task automatic wait_busy;
		repeat (3) @(negedge clock_in);
		while (busy_out !== 1'b0) @(negedge clock_in);
	endtask
	task automatic conv;
		wr(CMD_SINGLE_CONV, 8'h00);
		wait_busy();
	endtask
	// Window on the start counter; s brings the count at its opening, returns the difference
	task automatic cnt_st(input int n, inout int s);
		repeat (n) @(negedge clock_in);
		s = starts - s;
	endtask
	task automatic gap(output int n);
		while (adc_start_out !== 1'b1) @(negedge clock_in);
		n = 0;
		do begin
			@(negedge clock_in);
			n++;
		end while (adc_start_out !== 1'b1);
	endtask
	// =====
	// Main sequence
	initial begin
		cmd_in = '0;
		ara_rd_in = 1'b0;
		own_addr_in = 7'h4C;
		lt = 8'h00;
		rt = 8'h00;
		diode_open_in = 1'b0;
		diode_short_in = 1'b0;
		hw_standby_pin_n_in = 1'b1;
		rst_in = 1'b1;
		repeat (8) @(negedge clock_in);
		rst_in = 1'b0;
		for (int i = 0; i < 9; i++) rdc(i[7:0], rst_tab[i]);
		wait_busy();
		wr(CMD_RATE_WR, 8'h05);
		rdc(CMD_RATE_RD, 8'h05);
		rdc(CMD_RATE_WR, 8'h00);
		// Pacing per code; the first gap may still run on the old reload
		foreach (rc[j]) begin
			wr(CMD_RATE_WR, rc[j]);
			gap(g);
			gap(g);
			p = FP << (7 - rc[j][2:0]);
			chk({7'h0, g >= p + LAT - 4 && g <= p + LAT + 8}, 8'h01);
		end
		wr(CMD_CONFIG_WR, 8'h40);
		wait_busy();
		k = starts;
		cnt_st(200, k);
		chk(k[7:0], 8'h00);
		k = starts;
		wr(CMD_SINGLE_CONV, 8'h00);
		chk({7'h0, busy_out}, 8'h01);
		wr(CMD_SINGLE_CONV, 8'h00);
		cnt_st(300, k);
		chk(k[7:0], 8'h01);
		lt = 8'h7F;
		rt = 8'hC9;
		conv();
		rdc(CMD_FLAG_BYTE_RD, 8'h48);
		chk({7'h0, alert_oe_out}, 8'h01);
		rdc(CMD_FLAG_BYTE_RD, 8'h48);
		rdc(CMD_LOCAL_TEMP_RD, 8'h7F);
		rdc(CMD_REMOTE_TEMP_RD, 8'hC9);
		wr(CMD_LOCAL_LO_LIM_WR, 8'h1E);
		wr(CMD_REMOTE_HI_LIM_WR, 8'h14);
		lt = 8'h19;
		rt = 8'h19;
		conv();
		rdc(CMD_FLAG_BYTE_RD, 8'h78);
		rdc(CMD_FLAG_BYTE_RD, 8'h30);
		chk(ara_data_out, 8'h99);
		wr(CMD_CONFIG_WR, 8'hC0);
		chk({7'h0, alert_oe_out}, 8'h00);
		ara();
		wr(CMD_CONFIG_WR, 8'h40);
		chk({7'h0, alert_oe_out}, 8'h01);
		ara();
		chk({7'h0, alert_oe_out}, 8'h01);
		wr(CMD_LOCAL_LO_LIM_WR, 8'hC9);
		wr(CMD_REMOTE_HI_LIM_WR, 8'h7F);
		ara();
		chk({7'h0, alert_oe_out}, 8'h00);
		diode_short_in = 1'b1;
		conv();
		diode_short_in = 1'b0;
		rdc(CMD_REMOTE_TEMP_RD, 8'h7F);
		chk({7'h0, alert_oe_out}, 8'h01);
		diode_open_in = 1'b1;
		conv();
		diode_open_in = 1'b0;
		rdc(CMD_REMOTE_TEMP_RD, 8'h7F);
		rdc(CMD_FLAG_BYTE_RD, 8'h34);
		rdc(CMD_FLAG_BYTE_RD, 8'h14);
		chk({7'h0, alert_oe_out}, 8'h01);
		hw_standby_pin_n_in = 1'b0;
		repeat (4) @(negedge clock_in);
		k = starts;
		wr(CMD_SINGLE_CONV, 8'h00);
		cnt_st(200, k);
		chk(k[7:0], 8'h00);
		hw_standby_pin_n_in = 1'b1;
		repeat (4) @(negedge clock_in);
		wr(CMD_SINGLE_CONV, 8'h00);
		repeat (4) @(negedge clock_in);
		chk({7'h0, busy_out}, 8'h01);
		hw_standby_pin_n_in = 1'b0;
		repeat (8) @(negedge clock_in);
		chk({7'h0, busy_out}, 8'h00);
		rdc(CMD_REMOTE_TEMP_RD, 8'h7F);
		hw_standby_pin_n_in = 1'b1;
		wr(CMD_RATE_WR, 8'h00);
		wr(CMD_CONFIG_WR, 8'h00);
		gap(g);
		wait_busy();
		k = starts;
		wr(CMD_SINGLE_CONV, 8'h00);
		cnt_st(3, k);
		chk(k[7:0], 8'h01);
		summarize();
	end
endmodule
bind tmal_core tmal_core_asserts tmal_core_asserts_i (.clock_in, .rst_in, .cmd_in, .rd_data_out,
	.rd_valid_out, .ara_rd_in, .ara_ack_out, .ara_data_out, .adc_start_out, .adc_done_in,
	.hw_standby_pin_n_in, .alert_n_out, .alert_oe_out, .busy_out);
`default_nettype wire

/* File: tmal_adc_model.sv */
// Purpose: Converter stand-in that answers start pulses after a fixed latency
// Assumes: The bench sets the results before each start
// Notes: Result lines show inverted data outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module tmal_adc_model #(
	parameter int LAT = 40
) (
	// Clock and handshake
	input wire logic clock_in,
	input wire logic start_in,
	output logic done_out,
	// Results
	input wire logic [7:0] lt_in,
	input wire logic [7:0] rt_in,
	output logic [7:0] lt_out,
	output logic [7:0] rt_out
);
	// =====
	// Countdown; a new start reloads it
	int cnt = 0;
	always @(posedge clock_in) begin
		if (start_in) cnt <= LAT;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	// Results are only valid with done, so no stale value can pass
	assign done_out = (cnt == 1);
	assign lt_out = done_out ? lt_in : ~lt_in;
	assign rt_out = done_out ? rt_in : ~rt_in;
endmodule
`default_nettype wire

/* File: tmal_core.sv */
// Purpose: Register, conversion pacing, limit compare and alert latch of a temp monitor
// Assumes: Command front end and ADC share clock_in; standby pin is asynchronous
// Notes: The alert pin is open drain, modelled as value plus output enable
//
// Summary of operation
// - Temperatures are 8-bit two's complement, one count per degree.
// - Free-running conversions paced by rate code, reset value 02h.
// - Only low three rate bits decode; 0.0625 Hz to 8 Hz doubling.
// - Rate is written and read back by separate command codes.
// - Four limits; each channel compared only with its own two.
// - Result at or past a limit sets its trip flag and alert.
// - High limits reset to 7Fh, low limits to C9h.
// - Single conversion command restarts a fresh cycle in free-running mode.
// - Single conversion command during a conversion is discarded.
// - In software standby it runs exactly one cycle, then stands by.
// - Hardware standby ignores the single conversion command.
// - Flag bit 7 busy, bit 2 diode open, bits 1 and 0 zero.
// - Bits 6 to 3 are local high, local low, remote high, remote low.
// - Flag byte readable only by its read command; reset clears flags.
// - Flags are sticky; a read clears them unless the condition persists.
// - Every flag except busy raises the alert.
// - Alert is active low and only pulls the line down.
// - Alert is latched; only an alert response read clears it.
// - Device answers alert response address reads while an unmasked alert is pending.
// - Alert response byte holds own address in bits 7..1, bit 0 one.
// - Alert response read releases the line unless the fault persists.
// - Config bit 7 set keeps the alert line undriven.
// - Hardware standby stops conversions and abandons one without updating.
// - Diode checked at conversion start; either fault stores 127, only open flags.
`timescale 1ns/1ps
`default_nettype none
module tmal_core
	import tmal_pkg::*;
#(
	parameter int FAST_PERIOD = FAST_PERIOD_CYC
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Decoded command from the SMBus front end
	input wire tmal_cmd_t cmd_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	// Alert response address read
	input wire logic ara_rd_in,
	output logic ara_ack_out,
	output logic [7:0] ara_data_out,
	// Own slave address from the address straps
	input wire logic [6:0] own_addr_in,
	// Converter handshake
	output logic adc_start_out,
	input wire logic adc_done_in,
	input wire logic [7:0] adc_local_in,
	input wire logic [7:0] adc_remote_in,
	input wire logic diode_open_in,
	input wire logic diode_short_in,
	// Hardware standby pin, low active, asynchronous
	input wire logic hw_standby_pin_n_in,
	// Open-drain alert line
	output logic alert_n_out,
	output logic alert_oe_out,
	// Status view
	output logic busy_out
);
	// ==========================================================
	// Elaboration check: slowest period must fit the 32-bit timer
	if (FAST_PERIOD < 1 || FAST_PERIOD > 32'h01FFFFFF) begin : g_bad_period
		$error("FAST_PERIOD out of range");
	end

	// Rate code to period; code 7 is fastest, each step down doubles
	function automatic logic [31:0] rate_period(input logic [2:0] code);
		logic [31:0] base;
		base = 32'(FAST_PERIOD);
		rate_period = base << (RATE_CODE_MAX - code);
	endfunction

	// Signed compare helpers: at or above, at or below
	function automatic logic at_or_above(input logic [7:0] t, input logic [7:0] lim);
		at_or_above = ($signed(t) >= $signed(lim));
	endfunction
	function automatic logic at_or_below(input logic [7:0] t, input logic [7:0] lim);
		at_or_below = ($signed(t) <= $signed(lim));
	endfunction

	// ==========================================================
	// Standby pin synchroniser
	logic hw_standby_pin_meta_ff, hw_standby_pin_sync_ff;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			hw_standby_pin_meta_ff <= 1'b1;
			hw_standby_pin_sync_ff <= 1'b1;
		end else begin
			hw_standby_pin_meta_ff <= hw_standby_pin_n_in;
			hw_standby_pin_sync_ff <= hw_standby_pin_meta_ff;
		end
	end
	logic hw_hw_standby_pin;
	assign hw_hw_standby_pin = ~hw_standby_pin_sync_ff;

	// ==========================================================
	// State
	tmal_state_t state_ff, nxt_state;
	logic [31:0] timer_ff, nxt_timer;
	logic [7:0] local_temp_ff, nxt_local_temp;
	logic [7:0] remote_temp_ff, nxt_remote_temp;
	logic [7:0] rate_ff, nxt_rate;
	logic [7:0] cfg_ff, nxt_cfg;
	logic [7:0] lhi_ff, nxt_lhi, llo_ff, nxt_llo;
	logic [7:0] rhi_ff, nxt_rhi, rlo_ff, nxt_rlo;
	tmal_flags_t flags_ff, nxt_flags;
	logic alert_ff, nxt_alert;
	logic open_lat_ff, nxt_open_lat, short_lat_ff, nxt_short_lat;
	logic [6:0] addr_ff, nxt_addr;
	logic addr_init_ff;
	logic [7:0] rd_data_ff, nxt_rd_data;
	logic rd_valid_ff, nxt_rd_valid;
	logic start_ff, nxt_start;

	// Live fault conditions from the stored results
	tmal_flags_t cond, events;
	logic [7:0] flag_byte;
	logic wr_cmd, rd_cmd, conv_done, conv_go;
	logic [7:0] new_remote;

	always_comb begin
		cond.lhi = at_or_above(local_temp_ff, lhi_ff);
		cond.llo = at_or_below(local_temp_ff, llo_ff);
		cond.rhi = at_or_above(remote_temp_ff, rhi_ff);
		cond.rlo = at_or_below(remote_temp_ff, rlo_ff);
		cond.open = open_lat_ff;
	end

	// Flag byte layout with busy live and reserved bits zero
	assign flag_byte = {state_ff == TMAL_CONV, flags_ff.lhi, flags_ff.llo,
		flags_ff.rhi, flags_ff.rlo, flags_ff.open, 2'b00};

	assign wr_cmd = cmd_in.valid & cmd_in.wr;
	assign rd_cmd = cmd_in.valid & ~cmd_in.wr;
	assign conv_done = (state_ff == TMAL_CONV) & adc_done_in & ~hw_hw_standby_pin;
	// Faulted diode forces full scale on the remote channel
	assign new_remote = (open_lat_ff | short_lat_ff) ? TEMP_FAULT_VALUE : adc_remote_in;

	// ==========================================================
	// Register writes and read-back
	always_comb begin
		nxt_rate = rate_ff;
		nxt_cfg = cfg_ff;
		nxt_lhi = lhi_ff;
		nxt_llo = llo_ff;
		nxt_rhi = rhi_ff;
		nxt_rlo = rlo_ff;
		nxt_rd_data = rd_data_ff;
		nxt_rd_valid = rd_cmd;
		if (wr_cmd) begin
			case (cmd_in.code)
				CMD_CONFIG_WR: nxt_cfg = cmd_in.data;
				CMD_RATE_WR: nxt_rate = cmd_in.data;
				CMD_LOCAL_HI_LIM_WR: nxt_lhi = cmd_in.data;
				CMD_LOCAL_LO_LIM_WR: nxt_llo = cmd_in.data;
				CMD_REMOTE_HI_LIM_WR: nxt_rhi = cmd_in.data;
				CMD_REMOTE_LO_LIM_WR: nxt_rlo = cmd_in.data;
				default: nxt_rate = rate_ff;
			endcase
		end
		// Read of a write-only code returns zero
		if (rd_cmd) begin
			case (cmd_in.code)
				CMD_LOCAL_TEMP_RD: nxt_rd_data = local_temp_ff;
				CMD_REMOTE_TEMP_RD: nxt_rd_data = remote_temp_ff;
				CMD_FLAG_BYTE_RD: nxt_rd_data = flag_byte;
				CMD_CONFIG_RD: nxt_rd_data = cfg_ff;
				CMD_RATE_RD: nxt_rd_data = rate_ff;
				CMD_LOCAL_HI_LIM_RD: nxt_rd_data = lhi_ff;
				CMD_LOCAL_LO_LIM_RD: nxt_rd_data = llo_ff;
				CMD_REMOTE_HI_LIM_RD: nxt_rd_data = rhi_ff;
				CMD_REMOTE_LO_LIM_RD: nxt_rd_data = rlo_ff;
				default: nxt_rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rate_ff <= RST_RATE;
			cfg_ff <= RST_CONFIG;
			lhi_ff <= RST_HI_LIMIT;
			llo_ff <= RST_LO_LIMIT;
			rhi_ff <= RST_HI_LIMIT;
			rlo_ff <= RST_LO_LIMIT;
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else begin
			rate_ff <= nxt_rate;
			cfg_ff <= nxt_cfg;
			lhi_ff <= nxt_lhi;
			llo_ff <= nxt_llo;
			rhi_ff <= nxt_rhi;
			rlo_ff <= nxt_rlo;
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	// ==========================================================
	// Conversion pacing and sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		nxt_start = 1'b0;
		nxt_local_temp = local_temp_ff;
		nxt_remote_temp = remote_temp_ff;
		nxt_open_lat = open_lat_ff;
		nxt_short_lat = short_lat_ff;
		nxt_addr = addr_ff;
		conv_go = 1'b0;
		case (state_ff)
			TMAL_IDLE: begin
				// Free-running needs neither standby; the timer holds otherwise
				if (!hw_hw_standby_pin && !cfg_ff[CFG_HW_STANDBY_PIN_BIT] && timer_ff != 32'h0) begin
					nxt_timer = timer_ff - 32'h1;
				end
				if (hw_hw_standby_pin) begin
					conv_go = 1'b0;
				end else if (cmd_in.valid && cmd_in.wr && cmd_in.code == CMD_SINGLE_CONV) begin
					conv_go = 1'b1;
				end else if (!cfg_ff[CFG_HW_STANDBY_PIN_BIT] && timer_ff == 32'h0) begin
					conv_go = 1'b1;
				end
				if (conv_go) begin
					nxt_state = TMAL_CONV;
					nxt_start = 1'b1;
					nxt_timer = rate_period(rate_ff[RATE_CODE_W-1:0]);
					nxt_open_lat = diode_open_in;
					nxt_short_lat = diode_short_in;
					nxt_addr = own_addr_in;
				end
			end
			TMAL_CONV: begin
				// Single conversion requests here are dropped, not queued
				if (hw_hw_standby_pin) begin
					nxt_state = TMAL_IDLE;
				end else if (adc_done_in) begin
					nxt_state = TMAL_IDLE;
					nxt_local_temp = adc_local_in;
					nxt_remote_temp = new_remote;
				end else begin
					nxt_state = TMAL_CONV;
				end
			end
			default: nxt_state = TMAL_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_ff <= TMAL_IDLE;
			timer_ff <= 32'h0;
			start_ff <= 1'b0;
			local_temp_ff <= RST_TEMP;
			remote_temp_ff <= RST_TEMP;
			open_lat_ff <= 1'b0;
			short_lat_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			start_ff <= nxt_start;
			local_temp_ff <= nxt_local_temp;
			remote_temp_ff <= nxt_remote_temp;
			open_lat_ff <= nxt_open_lat;
			short_lat_ff <= nxt_short_lat;
		end
	end

	// Address straps caught after reset release and at each conversion start
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			addr_init_ff <= 1'b1;
			addr_ff <= 7'h00;
		end else begin
			addr_init_ff <= 1'b0;
			addr_ff <= addr_init_ff ? own_addr_in : nxt_addr;
		end
	end

	// ==========================================================
	// Sticky flags and alert latch
	always_comb begin
		// Trip events come from the converter results as they are being stored at cycle end
		events.lhi = conv_done & at_or_above(adc_local_in, lhi_ff);
		events.llo = conv_done & at_or_below(adc_local_in, llo_ff);
		events.rhi = conv_done & at_or_above(new_remote, rhi_ff);
		events.rlo = conv_done & at_or_below(new_remote, rlo_ff);
		events.open = conv_done & open_lat_ff;
		nxt_flags = flags_ff;
		// Read clear keeps persisting conditions; a new event wins the clear
		if (rd_cmd && cmd_in.code == CMD_FLAG_BYTE_RD) begin
			nxt_flags = flags_ff & cond;
		end
		nxt_flags = nxt_flags | events;
		nxt_alert = alert_ff;
		if (ara_rd_in && alert_ff && !cfg_ff[CFG_MASK_BIT]) begin
			nxt_alert = |cond;
		end
		if (|events) begin
			nxt_alert = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			flags_ff <= '0;
			alert_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			alert_ff <= nxt_alert;
		end
	end

	// ==========================================================
	// Outputs
	assign rd_data_out = rd_data_ff;
	assign rd_valid_out = rd_valid_ff;
	assign adc_start_out = start_ff;
	assign busy_out = (state_ff == TMAL_CONV);
	// Masked alerts stay latched but the line is left to the pull-up
	assign alert_oe_out = alert_ff & ~cfg_ff[CFG_MASK_BIT];
	assign alert_n_out = 1'b0;
	assign ara_ack_out = alert_oe_out;
	assign ara_data_out = {addr_ff, 1'b1};
endmodule
`default_nettype wire

/* File: tmal_core_asserts.sv */
// Purpose: Port-level properties of the alarm core
// Assumes: Bound to tmal_core, one clock domain
// Notes: Latch checks allow for config writes that change the mask
`timescale 1ns/1ps
`default_nettype none
module tmal_core_asserts
	import tmal_pkg::*;
(
	// Watched ports
	input wire logic clock_in,
	input wire logic rst_in,
	input wire tmal_cmd_t cmd_in,
	input wire logic [7:0] rd_data_out,
	input wire logic rd_valid_out,
	input wire logic ara_rd_in,
	input wire logic ara_ack_out,
	input wire logic [7:0] ara_data_out,
	input wire logic adc_start_out,
	input wire logic adc_done_in,
	input wire logic hw_standby_pin_n_in,
	input wire logic alert_n_out,
	input wire logic alert_oe_out,
	input wire logic busy_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// =====
	// Request qualifiers
	logic rd_req;
	logic flag_rd;
	logic cfg_wr;
	assign rd_req = cmd_in.valid && !cmd_in.wr;
	assign flag_rd = rd_req && (cmd_in.code == CMD_FLAG_BYTE_RD);
	assign cfg_wr = cmd_in.valid && cmd_in.wr && (cmd_in.code == CMD_CONFIG_WR);
	// Pin low long enough to pass the synchroniser
	sequence s_hw_standby_pin; !hw_standby_pin_n_in [*5]; endsequence
	sequence s_idle2; !busy_out [*2]; endsequence
	property p_rd_ans; rd_req |=> rd_valid_out; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_only; rd_valid_out |-> $past(rd_req); endproperty
	a_rd_only: assert property (p_rd_only) else $error("answer without read");
	property p_flag_bits;
		flag_rd |=> rd_data_out[1:0] == 2'h0 && rd_data_out[7] == $past(busy_out);
	endproperty
	a_flag_bits: assert property (p_flag_bits) else $error("flag byte bits wrong");
	property p_start; adc_start_out |-> busy_out ##1 !adc_start_out; endproperty
	a_start: assert property (p_start) else $error("start pulse wrong");
	property p_hw_standby_pin; s_hw_standby_pin |-> !adc_start_out; endproperty
	a_hw_standby_pin: assert property (p_hw_standby_pin) else $error("start in hw standby");
	property p_done; busy_out && adc_done_in |=> s_idle2; endproperty
	a_done: assert property (p_done) else $error("busy after done");
	property p_ack; ara_ack_out == alert_oe_out; endproperty
	a_ack: assert property (p_ack) else $error("ara answer mismatch");
	property p_drain; alert_n_out == 1'b0; endproperty
	a_drain: assert property (p_drain) else $error("alert drives high");
	property p_ara_b0; ara_data_out[0] == 1'b1; endproperty
	a_ara_b0: assert property (p_ara_b0) else $error("ara bit 0 low");
	property p_latch; alert_oe_out && !ara_rd_in && !cfg_wr |=> alert_oe_out; endproperty
	a_latch: assert property (p_latch) else $error("alert dropped");
	property p_raise;
		$rose(alert_oe_out) |-> $past(adc_done_in || cfg_wr) || $past(adc_done_in || cfg_wr, 2);
	endproperty
	a_raise: assert property (p_raise) else $error("alert without cause");
endmodule
`default_nettype wire

/* File: tmal_pkg.sv */
// Purpose: Shared constants and types for the temperature monitor alarm logic
// Assumes: 8-bit command codes decoded by an SMBus slave front end
// Notes: Reset values and bit positions live here only
package tmal_pkg;
	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_LOCAL_TEMP_RD = 8'h00;
	localparam logic [7:0] CMD_REMOTE_TEMP_RD = 8'h01;
	localparam logic [7:0] CMD_FLAG_BYTE_RD = 8'h02;
	localparam logic [7:0] CMD_CONFIG_RD = 8'h03;
	localparam logic [7:0] CMD_RATE_RD = 8'h04;
	localparam logic [7:0] CMD_LOCAL_HI_LIM_RD = 8'h05;
	localparam logic [7:0] CMD_LOCAL_LO_LIM_RD = 8'h06;
	localparam logic [7:0] CMD_REMOTE_HI_LIM_RD = 8'h07;
	localparam logic [7:0] CMD_REMOTE_LO_LIM_RD = 8'h08;
	localparam logic [7:0] CMD_CONFIG_WR = 8'h09;
	localparam logic [7:0] CMD_RATE_WR = 8'h0A;
	localparam logic [7:0] CMD_LOCAL_HI_LIM_WR = 8'h0B;
	localparam logic [7:0] CMD_LOCAL_LO_LIM_WR = 8'h0C;
	localparam logic [7:0] CMD_REMOTE_HI_LIM_WR = 8'h0D;
	localparam logic [7:0] CMD_REMOTE_LO_LIM_WR = 8'h0E;
	localparam logic [7:0] CMD_SINGLE_CONV = 8'h0F;
	// ==========================================================
	// Reset values and diode fault value
	localparam logic [7:0] RST_TEMP = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h02;
	localparam logic [7:0] RST_HI_LIMIT = 8'h7F;
	localparam logic [7:0] RST_LO_LIMIT = 8'hC9;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] TEMP_FAULT_VALUE = 8'h7F;
	// ==========================================================
	// Field positions
	localparam int CFG_MASK_BIT = 7;
	localparam int CFG_HW_STANDBY_PIN_BIT = 6;
	localparam int FLG_BUSY_BIT = 7;
	localparam int FLG_LHI_BIT = 6;
	localparam int FLG_LLO_BIT = 5;
	localparam int FLG_RHI_BIT = 4;
	localparam int FLG_RLO_BIT = 3;
	localparam int FLG_OPEN_BIT = 2;
	localparam int RATE_CODE_W = 3;
	localparam logic [2:0] RATE_CODE_MAX = 3'h7;
	// ==========================================================
	// Timing: fastest rate period, slower codes double it
	localparam int RATE_MAX_HZ = 8;
	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int FAST_PERIOD_CYC = CLK_FREQ_HZ / RATE_MAX_HZ;
	// ==========================================================
	// Types
	typedef struct packed {
		logic valid;
		logic wr;
		logic [7:0] code;
		logic [7:0] data;
	} tmal_cmd_t;
	typedef struct packed {
		logic lhi;
		logic llo;
		logic rhi;
		logic rlo;
		logic open;
	} tmal_flags_t;
	typedef enum logic {
		TMAL_IDLE,
		TMAL_CONV
	} tmal_state_t;
endpackage
